/* verilog/dpc_map.svh */
`ifndef DPC_MAP_SVH
`define DPC_MAP_SVH

// Register offsets
`define DPC_OFS_PLAYBACK_CTRL     8'h21
`define DPC_OFS_GAIN_STATUS       8'h22
`define DPC_OFS_RAMP_STATUS       8'h23

// Playback control field positions
`define DPC_BIT_EMPH_LO           1
`define DPC_BIT_EMPH_HI           2
`define DPC_BIT_SOFT_MUTE         3
`define DPC_BIT_DOUBLE_OSR        6
`define DPC_BIT_UNMUTE_RAMP       9
`define DPC_BIT_RAMP_RATE         10
`define DPC_BIT_SLOPING_FILT      11
`define DPC_BIT_MONO_MIX          12

// Reset values
`define DPC_RST_PLAYBACK_CTRL     16'h0008
`define DPC_RST_GAIN              8'h00

// Gain code limits
`define DPC_CODE_UNITY            8'hc0
`define DPC_CODE_MUTE             8'h00

// Ramp periods in sample ticks, and the longest ramps they give at 48 kHz
`define DPC_RAMP_FAST_DIV         6'h02
`define DPC_RAMP_SLOW_DIV         6'h20
`define DPC_RAMP_FAST_MAX_MS      10.7
`define DPC_RAMP_SLOW_MAX_MS      171

`endif

/* verilog/dpc_pkg.sv */
`default_nettype none

package dpc_pkg;

	typedef logic signed [15:0] dpc_sample_t;
	typedef logic [7:0]         dpc_code_t;

	typedef enum logic [1:0] {
		DPC_LIVE,
		DPC_MUTING,
		DPC_MUTED,
		DPC_RAMP_UP
	} dpc_ramp_state_t;

endpackage : dpc_pkg

`default_nettype wire

/* verilog/dpc_fifo.sv */
`default_nettype none

module dpc_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wr_ptr_ff;
	logic [AW-1:0]    rd_ptr_ff;
	logic [AW:0]      count_ff;
	logic             out_valid_ff;
	logic [WIDTH-1:0] out_data_ff;
	logic             push;
	logic             pop;

	// Output register refills whenever it is empty or being drained
	assign in_ready  = (count_ff != (AW+1)'(DEPTH));
	assign push      = in_valid && in_ready;
	assign pop       = (count_ff != '0) && (!out_valid_ff || out_ready);
	assign out_valid = out_valid_ff;
	assign out_data  = out_data_ff;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			end
			count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			out_valid_ff <= 1'b0;
			out_data_ff  <= '0;
		end else if (pop) begin
			out_valid_ff <= 1'b1;
			out_data_ff  <= mem_ff[rd_ptr_ff];
		end else if (out_ready) begin
			out_valid_ff <= 1'b0;
		end
	end

endmodule : dpc_fifo

`default_nettype wire

/* verilog/dpc_playback.sv */
`include "dpc_map.svh"
`default_nettype none

module dpc_playback (
	// Clock and reset
	input  wire logic        MCLK,
	input  wire logic        SRST,
	// Register port
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [15:0] REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic      [15:0] REG_RDATA,
	// Gains and converter enables
	input  wire logic [7:0]  LEFT_DIGITAL_GAIN,
	input  wire logic [7:0]  RIGHT_DIGITAL_GAIN,
	input  wire logic        LEFT_CONV_ENABLE,
	input  wire logic        RIGHT_CONV_ENABLE,
	// Sample rate tick, one cycle per sample period
	input  wire logic        FS_TICK,
	// Sample input
	input  wire logic        IN_VALID,
	output logic             IN_READY,
	input  wire logic [15:0] IN_LEFT,
	input  wire logic [15:0] IN_RIGHT,
	// Sample output
	output logic             OUT_VALID,
	input  wire logic        OUT_READY,
	output logic      [15:0] OUT_LEFT,
	output logic      [15:0] OUT_RIGHT,
	// Filter controls towards the converter
	output logic      [3:0]  EMPHASIS_FILTER_ONEHOT,
	output logic             SLOPING_STOP_FILTER_SEL,
	output logic             DOUBLE_OVERSAMPLE_SEL
);

	// Mapping of a code to unity-or-below gain
	function automatic dpc_pkg::dpc_code_t clamp_code(input dpc_pkg::dpc_code_t code);
		if (code >= `DPC_CODE_UNITY) begin
			clamp_code = `DPC_CODE_UNITY;
		end else begin
			clamp_code = code;
		end
	endfunction : clamp_code

	// 16 codes make exactly 6 dB, so a table of one octave plus a shift covers all
	function automatic logic [15:0] octave_mant(input logic [3:0] idx);
		unique case (idx)
			4'h0: octave_mant = 16'h8000;
			4'h1: octave_mant = 16'h7a93;
			4'h2: octave_mant = 16'h7560;
			4'h3: octave_mant = 16'h7066;
			4'h4: octave_mant = 16'h6ba2;
			4'h5: octave_mant = 16'h6712;
			4'h6: octave_mant = 16'h62b4;
			4'h7: octave_mant = 16'h5e84;
			4'h8: octave_mant = 16'h5a82;
			4'h9: octave_mant = 16'h56ac;
			4'ha: octave_mant = 16'h52ff;
			4'hb: octave_mant = 16'h4f7b;
			4'hc: octave_mant = 16'h4c1c;
			4'hd: octave_mant = 16'h48e2;
			4'he: octave_mant = 16'h45cb;
			4'hf: octave_mant = 16'h42d5;
		endcase
	endfunction : octave_mant

	function automatic dpc_pkg::dpc_sample_t apply_gain(
		input dpc_pkg::dpc_sample_t smp,
		input dpc_pkg::dpc_code_t   code
	);
		logic [7:0]         atten;
		logic signed [32:0] prod;
		atten = 8'h00;
		prod  = '0;
		if (code == `DPC_CODE_MUTE) begin
			apply_gain = '0;
		end else begin
			atten = `DPC_CODE_UNITY - clamp_code(code);
			prod  = 33'(smp) * $signed({17'h0_0000, octave_mant(atten[3:0])});
			prod  = prod >>> 15;
			prod  = prod >>> atten[7:4];
			apply_gain = prod[15:0];
		end
	endfunction : apply_gain

	// One code per call toward the goal
	function automatic dpc_pkg::dpc_code_t step_toward(
		input dpc_pkg::dpc_code_t cur,
		input dpc_pkg::dpc_code_t goal
	);
		if (cur < goal) begin
			step_toward = cur + 8'h01;
		end else if (cur > goal) begin
			step_toward = cur - 8'h01;
		end else begin
			step_toward = cur;
		end
	endfunction : step_toward

	// Control register fields
	logic [1:0]                emph_sel_ff;
	logic                      soft_mute_ff;
	logic                      double_osr_ff;
	logic                      unmute_ramp_ff;
	logic                      ramp_rate_ff;
	logic                      sloping_filt_ff;
	logic                      mono_mix_ff;
	logic [15:0]               ctrl_rd;
	logic [15:0]               rdata_ff;
	logic [15:0]               nxt_rdata;

	// Ramp state
	dpc_pkg::dpc_ramp_state_t  ramp_st_ff;
	dpc_pkg::dpc_ramp_state_t  nxt_ramp_st;
	dpc_pkg::dpc_code_t        eff_l_ff;
	dpc_pkg::dpc_code_t        eff_r_ff;
	dpc_pkg::dpc_code_t        nxt_eff_l;
	dpc_pkg::dpc_code_t        nxt_eff_r;
	logic [5:0]                tick_cnt_ff;
	logic [5:0]                ramp_div;
	logic                      ramp_step;

	// Sample path
	logic                      fifo_valid;
	logic                      fifo_ready;
	logic [31:0]               fifo_data;
	dpc_pkg::dpc_sample_t      src_l;
	dpc_pkg::dpc_sample_t      src_r;
	dpc_pkg::dpc_sample_t      mono_mix;
	dpc_pkg::dpc_sample_t      mix_l;
	dpc_pkg::dpc_sample_t      mix_r;
	logic signed [16:0]        mono_sum;
	logic                      mono_active;
	logic                      out_valid_ff;
	dpc_pkg::dpc_sample_t      out_l_ff;
	dpc_pkg::dpc_sample_t      out_r_ff;

	// Register writes
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			emph_sel_ff     <= 2'(`DPC_RST_PLAYBACK_CTRL >> `DPC_BIT_EMPH_LO);
			soft_mute_ff    <= 1'(`DPC_RST_PLAYBACK_CTRL >> `DPC_BIT_SOFT_MUTE);
			double_osr_ff   <= 1'(`DPC_RST_PLAYBACK_CTRL >> `DPC_BIT_DOUBLE_OSR);
			unmute_ramp_ff  <= 1'(`DPC_RST_PLAYBACK_CTRL >> `DPC_BIT_UNMUTE_RAMP);
			ramp_rate_ff    <= 1'(`DPC_RST_PLAYBACK_CTRL >> `DPC_BIT_RAMP_RATE);
			sloping_filt_ff <= 1'(`DPC_RST_PLAYBACK_CTRL >> `DPC_BIT_SLOPING_FILT);
			mono_mix_ff     <= 1'(`DPC_RST_PLAYBACK_CTRL >> `DPC_BIT_MONO_MIX);
		end else if (REG_WR && (REG_ADDR == `DPC_OFS_PLAYBACK_CTRL)) begin
			emph_sel_ff     <= REG_WDATA[`DPC_BIT_EMPH_HI:`DPC_BIT_EMPH_LO];
			soft_mute_ff    <= REG_WDATA[`DPC_BIT_SOFT_MUTE];
			double_osr_ff   <= REG_WDATA[`DPC_BIT_DOUBLE_OSR];
			unmute_ramp_ff  <= REG_WDATA[`DPC_BIT_UNMUTE_RAMP];
			ramp_rate_ff    <= REG_WDATA[`DPC_BIT_RAMP_RATE];
			sloping_filt_ff <= REG_WDATA[`DPC_BIT_SLOPING_FILT];
			mono_mix_ff     <= REG_WDATA[`DPC_BIT_MONO_MIX];
		end
	end

	always_comb begin
		ctrl_rd = 16'h0000;
		ctrl_rd[`DPC_BIT_EMPH_HI:`DPC_BIT_EMPH_LO] = emph_sel_ff;
		ctrl_rd[`DPC_BIT_SOFT_MUTE]    = soft_mute_ff;
		ctrl_rd[`DPC_BIT_DOUBLE_OSR]   = double_osr_ff;
		ctrl_rd[`DPC_BIT_UNMUTE_RAMP]  = unmute_ramp_ff;
		ctrl_rd[`DPC_BIT_RAMP_RATE]    = ramp_rate_ff;
		ctrl_rd[`DPC_BIT_SLOPING_FILT] = sloping_filt_ff;
		ctrl_rd[`DPC_BIT_MONO_MIX]     = mono_mix_ff;
	end

	// Read data stand for exactly one cycle; unmapped offsets read zero
	always_comb begin
		nxt_rdata = 16'h0000;
		if (REG_RD) begin
			unique case (REG_ADDR)
				`DPC_OFS_PLAYBACK_CTRL: nxt_rdata = ctrl_rd;
				`DPC_OFS_GAIN_STATUS:   nxt_rdata = {eff_r_ff, eff_l_ff};
				`DPC_OFS_RAMP_STATUS: begin
					nxt_rdata[0] = (ramp_st_ff == dpc_pkg::DPC_MUTING) ||
					               (ramp_st_ff == dpc_pkg::DPC_RAMP_UP);
					nxt_rdata[1] = (ramp_st_ff == dpc_pkg::DPC_MUTED);
					nxt_rdata[2] = mono_active;
					nxt_rdata[3] = !IN_READY;
				end
				default:                nxt_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			rdata_ff <= 16'h0000;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign REG_RDATA = rdata_ff;

	// Ramp period counter in sample ticks
	assign ramp_div  = ramp_rate_ff ? `DPC_RAMP_SLOW_DIV : `DPC_RAMP_FAST_DIV;
	assign ramp_step = FS_TICK && (tick_cnt_ff == ramp_div - 6'h01);

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			tick_cnt_ff <= 6'h00;
		end else if (ramp_step || (tick_cnt_ff >= ramp_div)) begin
			tick_cnt_ff <= 6'h00;
		end else if (FS_TICK) begin
			tick_cnt_ff <= tick_cnt_ff + 6'h01;
		end
	end

	// Mute and un-mute sequencing, both channels together
	always_comb begin
		nxt_ramp_st = ramp_st_ff;
		nxt_eff_l   = eff_l_ff;
		nxt_eff_r   = eff_r_ff;
		unique case (ramp_st_ff)
			dpc_pkg::DPC_LIVE: begin
				// Settled: gain changes pass straight through
				nxt_eff_l = LEFT_DIGITAL_GAIN;
				nxt_eff_r = RIGHT_DIGITAL_GAIN;
				if (soft_mute_ff) begin
					nxt_ramp_st = dpc_pkg::DPC_MUTING;
					nxt_eff_l   = eff_l_ff;
					nxt_eff_r   = eff_r_ff;
				end
			end
			dpc_pkg::DPC_MUTING, dpc_pkg::DPC_MUTED: begin
				if (!soft_mute_ff && !unmute_ramp_ff) begin
					nxt_ramp_st = dpc_pkg::DPC_LIVE;
					nxt_eff_l   = LEFT_DIGITAL_GAIN;
					nxt_eff_r   = RIGHT_DIGITAL_GAIN;
				end else if (!soft_mute_ff) begin
					nxt_ramp_st = dpc_pkg::DPC_RAMP_UP;
				end else if (ramp_step) begin
					nxt_eff_l = step_toward(eff_l_ff, `DPC_CODE_MUTE);
					nxt_eff_r = step_toward(eff_r_ff, `DPC_CODE_MUTE);
					if ((nxt_eff_l == `DPC_CODE_MUTE) && (nxt_eff_r == `DPC_CODE_MUTE)) begin
						nxt_ramp_st = dpc_pkg::DPC_MUTED;
					end
				end
			end
			dpc_pkg::DPC_RAMP_UP: begin
				if (soft_mute_ff) begin
					nxt_ramp_st = dpc_pkg::DPC_MUTING;
				end else if ((eff_l_ff == LEFT_DIGITAL_GAIN) &&
				             (eff_r_ff == RIGHT_DIGITAL_GAIN)) begin
					nxt_ramp_st = dpc_pkg::DPC_LIVE;
				end else if (ramp_step) begin
					nxt_eff_l = step_toward(eff_l_ff, LEFT_DIGITAL_GAIN);
					nxt_eff_r = step_toward(eff_r_ff, RIGHT_DIGITAL_GAIN);
				end
			end
		endcase
	end

	// Playback starts muted at zero gain
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			ramp_st_ff <= dpc_pkg::DPC_MUTED;
			eff_l_ff   <= `DPC_RST_GAIN;
			eff_r_ff   <= `DPC_RST_GAIN;
		end else begin
			ramp_st_ff <= nxt_ramp_st;
			eff_l_ff   <= nxt_eff_l;
			eff_r_ff   <= nxt_eff_r;
		end
	end

	// Input buffer; a stalled output backs up into IN_READY
	dpc_fifo #(
		.WIDTH (32),
		.DEPTH (16)
	) u_fifo (
		.clk       (MCLK),
		.rst       (SRST),
		.in_valid  (IN_VALID),
		.in_ready  (IN_READY),
		.in_data   ({IN_LEFT, IN_RIGHT}),
		.out_valid (fifo_valid),
		.out_ready (fifo_ready),
		.out_data  (fifo_data)
	);

	assign src_l = fifo_data[31:16];
	assign src_r = fifo_data[15:0];

	// Halving the sum is the 6 dB cut that keeps the mix from clipping
	assign mono_sum    = 17'(src_l) + 17'(src_r);
	assign mono_mix    = mono_sum[16:1];
	assign mono_active = mono_mix_ff && (LEFT_CONV_ENABLE != RIGHT_CONV_ENABLE);

	always_comb begin
		mix_l = src_l;
		mix_r = src_r;
		if (mono_active) begin
			mix_l = mono_mix;
			mix_r = mono_mix;
		end
		if (!LEFT_CONV_ENABLE) begin
			mix_l = '0;
		end
		if (!RIGHT_CONV_ENABLE) begin
			mix_r = '0;
		end
	end

	assign fifo_ready = !out_valid_ff || OUT_READY;

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			out_valid_ff <= 1'b0;
			out_l_ff     <= '0;
			out_r_ff     <= '0;
		end else if (fifo_valid && fifo_ready) begin
			out_valid_ff <= 1'b1;
			out_l_ff     <= apply_gain(mix_l, eff_l_ff);
			out_r_ff     <= apply_gain(mix_r, eff_r_ff);
		end else if (OUT_READY) begin
			out_valid_ff <= 1'b0;
		end
	end

	assign OUT_VALID = out_valid_ff;
	assign OUT_LEFT  = out_l_ff;
	assign OUT_RIGHT = out_r_ff;

	// Emphasis selection goes out one-hot decoded for the converter; the other filter selects pass through as stored
	always_comb begin
		EMPHASIS_FILTER_ONEHOT = 4'h0;
		EMPHASIS_FILTER_ONEHOT[emph_sel_ff] = 1'b1;
	end

	assign SLOPING_STOP_FILTER_SEL = sloping_filt_ff;
	assign DOUBLE_OVERSAMPLE_SEL   = double_osr_ff;

endmodule : dpc_playback

`default_nettype wire

/* verification/dpc_playback_asserts.sv */
`default_nettype none

module dpc_playback_chk (
	// Clock and reset
	input wire logic        MCLK,
	input wire logic        SRST,
	// Register port
	input wire logic [7:0]  REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic        REG_WR,
	input wire logic        REG_RD,
	input wire logic [15:0] REG_RDATA,
	// Stream and filter controls
	input wire logic        LEFT_CONV_ENABLE,
	input wire logic        RIGHT_CONV_ENABLE,
	input wire logic        IN_READY,
	input wire logic        OUT_VALID,
	input wire logic        OUT_READY,
	input wire logic [15:0] OUT_LEFT,
	input wire logic [15:0] OUT_RIGHT,
	input wire logic [3:0]  EMPHASIS_FILTER_ONEHOT,
	input wire logic        SLOPING_STOP_FILTER_SEL,
	input wire logic        DOUBLE_OVERSAMPLE_SEL
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking @(posedge MCLK); endclocking
	default disable iff (SRST);

	// Writable bits only, so reserved bits must read back as 0
	logic [15:0] shadow_ff;
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			shadow_ff <= 16'h0008;
		end else if (REG_WR && REG_ADDR == 8'h21) begin
			shadow_ff <= REG_WDATA & 16'h1e4e;
		end
	end

	ctrl_readback_a: assert property (REG_RD && REG_ADDR == 8'h21 |=> REG_RDATA == shadow_ff)
		else $error("control read back differs");
	rd_idle_a: assert property (!REG_RD |=> REG_RDATA == 16'h0000)
		else $error("read data outside read cycle");
	emph_decode_a: assert property (EMPHASIS_FILTER_ONEHOT == 4'h1 << shadow_ff[2:1])
		else $error("emphasis select wrong");
	slope_sel_a: assert property (SLOPING_STOP_FILTER_SEL == shadow_ff[11])
		else $error("filter type select wrong");
	osr_sel_a: assert property (DOUBLE_OVERSAMPLE_SEL == shadow_ff[6])
		else $error("oversample select wrong");
	left_silent_a: assert property (OUT_VALID && !LEFT_CONV_ENABLE |-> OUT_LEFT == 16'h0000)
		else $error("disabled left not silent");
	right_silent_a: assert property (OUT_VALID && !RIGHT_CONV_ENABLE |-> OUT_RIGHT == 16'h0000)
		else $error("disabled right not silent");
	out_hold_a: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_LEFT))
		else $error("output word dropped while stalled");

	cover property (REG_WR && REG_ADDR == 8'h21 && REG_WDATA[12]);
	cover property (OUT_VALID && !OUT_READY);
	cover property (!IN_READY);
endmodule : dpc_playback_chk

bind dpc_playback dpc_playback_chk u_dpc_playback_chk (
	.MCLK                    (MCLK),
	.SRST                    (SRST),
	.REG_ADDR                (REG_ADDR),
	.REG_WDATA               (REG_WDATA),
	.REG_WR                  (REG_WR),
	.REG_RD                  (REG_RD),
	.REG_RDATA               (REG_RDATA),
	.LEFT_CONV_ENABLE        (LEFT_CONV_ENABLE),
	.RIGHT_CONV_ENABLE       (RIGHT_CONV_ENABLE),
	.IN_READY                (IN_READY),
	.OUT_VALID               (OUT_VALID),
	.OUT_READY               (OUT_READY),
	.OUT_LEFT                (OUT_LEFT),
	.OUT_RIGHT               (OUT_RIGHT),
	.EMPHASIS_FILTER_ONEHOT  (EMPHASIS_FILTER_ONEHOT),
	.SLOPING_STOP_FILTER_SEL (SLOPING_STOP_FILTER_SEL),
	.DOUBLE_OVERSAMPLE_SEL   (DOUBLE_OVERSAMPLE_SEL)
);

`default_nettype wire

/* verification/dpc_src_model.sv */
`default_nettype none

module dpc_src_model (
	// Clock
	input  wire logic        clk,
	// Sample stream
	output logic             valid,
	input  wire logic        ready,
	output logic      [15:0] left,
	output logic      [15:0] right
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		valid = 1'b0;
		left = 16'h0000;
		right = 16'h0000;
	end

	task send(input logic [15:0] l, input logic [15:0] r);
		repeat ($urandom_range(1, 0)) @(posedge clk);
		@(posedge clk);
		valid <= 1'b1;
		left <= l;
		right <= r;
		do @(posedge clk); while (!ready);
		// Stale data must not pass for a repeat of the word
		valid <= 1'b0;
		left <= ~l;
		right <= ~r;
	endtask : send
endmodule : dpc_src_model

`default_nettype wire

/* verification/test_dpc_playback.sv */
`default_nettype none

module test_dpc_playback;
	timeunit 1ns;
	timeprecision 1ps;

	logic        mclk, srst, reg_wr, reg_rd, fs_tick, in_valid, in_ready;
	logic        out_valid, out_ready, l_en, r_en, sl_sel, osr_sel, stall;
	logic [1:0]  tcnt;
	logic [3:0]  emph;
	logic [7:0]  reg_addr, l_gain, r_gain;
	logic [15:0] reg_wdata, reg_rdata, in_l, in_r, out_l, out_r, rd;
	logic [15:0] q_l[$], q_r[$];
	int          failures, num_checks, mode, wt;

	dpc_src_model u_dpc_src_model (.clk(mclk), .valid(in_valid), .ready(in_ready),
		.left(in_l), .right(in_r));

	dpc_playback u_dpc_playback (.MCLK(mclk), .SRST(srst), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
		.LEFT_DIGITAL_GAIN(l_gain), .RIGHT_DIGITAL_GAIN(r_gain), .LEFT_CONV_ENABLE(l_en),
		.RIGHT_CONV_ENABLE(r_en), .FS_TICK(fs_tick), .IN_VALID(in_valid),
		.IN_READY(in_ready), .IN_LEFT(in_l), .IN_RIGHT(in_r), .OUT_VALID(out_valid),
		.OUT_READY(out_ready), .OUT_LEFT(out_l), .OUT_RIGHT(out_r),
		.EMPHASIS_FILTER_ONEHOT(emph), .SLOPING_STOP_FILTER_SEL(sl_sel),
		.DOUBLE_OVERSAMPLE_SEL(osr_sel));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// One sample tick every four clocks keeps ramps short
	always @(posedge mclk) begin
		tcnt <= srst ? 2'h0 : tcnt + 2'h1;
		fs_tick <= !srst && (tcnt == 2'h3);
		out_ready <= !stall && ($urandom_range(3, 0) != 0);
	end

	task cmp(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : cmp

	task rng(input logic [15:0] got, input int lo, input int hi);
		num_checks++;
		if ($isunknown(got) || int'(got) < lo || int'(got) > hi) begin
			failures++;
			$display("unexpected at %0t: got %h exp %h..%h", $time, got, lo, hi);
		end
	endtask : rng

	task tally_and_finish;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : tally_and_finish

	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr

	task rdr(input logic [7:0] a);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 rd = reg_rdata;
	endtask : rdr

	always @(posedge mclk) begin
		if (out_valid && out_ready && q_l.size() > 0)
			check_out(q_l.pop_front(), q_r.pop_front());
	end

	task check_out(input logic [15:0] l, input logic [15:0] r);
		logic [15:0] mix;
		mix = 16'((int'(l) + int'(r)) / 2);
		case (mode)
			0: begin
				cmp(out_l, l);
				cmp(out_r, r);
			end
			1: begin
				rng(out_l, int'(l) * 945 / 1000, int'(l) * 958 / 1000 + 1);
				rng(out_r, int'(r) * 945 / 1000, int'(r) * 958 / 1000 + 1);
			end
			2: begin
				cmp(out_l, mix);
				cmp(out_r, 16'h0000);
			end
			default: begin
				cmp(out_l, 16'h0000);
				cmp(out_r, mix);
			end
		endcase
	endtask : check_out

	task stream(input int n, input int m);
		logic [15:0] a, b;
		int w;
		mode = m;
		for (int i = 0; i < n; i++) begin
			a = 16'($urandom_range(32767, 1000));
			b = 16'($urandom_range(32767, 1000));
			q_l.push_back(a);
			q_r.push_back(b);
			u_dpc_src_model.send(a, b);
		end
		w = 0;
		while (q_l.size() > 0 && w < 3000) begin
			@(posedge mclk);
			w++;
		end
		if (q_l.size() > 0) begin
			failures++;
			tally_and_finish();
		end
		$display("stream test mode %0d done", m);
	endtask : stream

	initial begin
		repeat (100000) @(posedge mclk);
		failures++;
		tally_and_finish();
	end

	initial begin
		{srst, reg_wr, reg_rd, reg_addr, reg_wdata, stall} = '0;
		{l_en, r_en, l_gain, r_gain, failures, num_checks, mode} = '0;
		srst = 1'b1;
		l_en = 1'b1;
		r_en = 1'b1;
		wt = $urandom(96);
		repeat (4) @(posedge mclk);
		srst <= 1'b0;
		rdr(8'h21);
		cmp(rd, 16'h0008);
		rdr(8'h40);
		cmp(rd, 16'h0000);
		for (int e = 0; e < 4; e++) begin
			wr(8'h21, 16'(e << 1));
			@(posedge mclk);
			cmp(16'(emph), 16'(1 << e));
		end
		wr(8'h21, 16'h0840);
		@(posedge mclk);
		cmp(16'({sl_sel, osr_sel}), 16'h0003);
		$display("register test done");
		l_gain <= 8'($urandom_range(255, 192));
		r_gain <= 8'($urandom_range(255, 192));
		wr(8'h21, 16'h1000);
		rdr(8'h22);
		cmp(rd, {r_gain, l_gain});
		// Hold the sink off until the buffer refuses
		stall <= 1'b1;
		fork
			stream(24, 0);
		join_none
		wt = 0;
		while (in_ready && wt < 300) begin
			@(posedge mclk);
			wt++;
		end
		cmp(16'(in_ready), 16'h0000);
		// Full buffer shows in status; both enables set keep mono inactive
		rdr(8'h23);
		cmp(rd, 16'h0008);
		stall <= 1'b0;
		wait fork;
		l_gain <= 8'hbf;
		r_gain <= 8'hbf;
		stream(6, 1);
		l_gain <= 8'hc0;
		r_gain <= 8'hc0;
		r_en <= 1'b0;
		stream(6, 2);
		rdr(8'h23);
		cmp(rd, 16'h0004);
		l_en <= 1'b0;
		r_en <= 1'b1;
		stream(6, 3);
		l_en <= 1'b1;
		wr(8'h21, 16'h0008);
		repeat (32) @(posedge mclk);
		rdr(8'h22);
		rng(16'(rd[7:0]), 187, 189);
		rdr(8'h23);
		cmp(rd, 16'h0001);
		wr(8'h21, 16'h0000);
		wr(8'h21, 16'h0408);
		repeat (256) @(posedge mclk);
		rdr(8'h22);
		rng(16'(rd[7:0]), 189, 191);
		wr(8'h21, 16'h0000);
		l_gain <= 8'h10;
		r_gain <= 8'h10;
		wr(8'h21, 16'h0008);
		repeat (200) @(posedge mclk);
		rdr(8'h22);
		cmp(rd, 16'h0000);
		rdr(8'h23);
		cmp(rd, 16'h0002);
		l_gain <= 8'hc0;
		r_gain <= 8'hc0;
		wr(8'h21, 16'h0200);
		repeat (32) @(posedge mclk);
		rdr(8'h22);
		rng(16'(rd[7:0]), 3, 5);
		$display("ramp test done");
		tally_and_finish();
	end
endmodule : test_dpc_playback

`default_nettype wire
